//--- src/oppt_regs.vh
// constants of the one-shot pulse timer card: register map, fields, timing
// assumes a 100 MHz core clock and a 32-bit apb register bus
`ifndef OPPT_REGS_VH
`define OPPT_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OPPT_ADDR_W        5
`define OPPT_OFS_CTRL      5'h00
`define OPPT_OFS_DATA      5'h04
`define OPPT_OFS_ADDRW     5'h08
`define OPPT_OFS_READBACK  5'h0c
`define OPPT_OFS_STATUS    5'h10

// ----------------------------------------------------------------------
// control word fields, address word gate bit and readback request bit
// ----------------------------------------------------------------------
`define OPPT_CTRL_W        5
`define OPPT_CTRL_RST      5'h00
`define OPPT_BIT_XFER      0
`define OPPT_BIT_SYNC      1
`define OPPT_BIT_TIMING    2
`define OPPT_BIT_ISEL      3
`define OPPT_BIT_ARM       4
`define OPPT_BIT_GATE      0
`define OPPT_BIT_REQ       15

// ----------------------------------------------------------------------
// count and timing
// ----------------------------------------------------------------------
`define OPPT_COUNT_W       12
`define OPPT_COUNT_RST     12'h000
`define OPPT_CLK_PERIOD_NS 10
`define OPPT_INCR_MIN_NS   1000
`define OPPT_INCR_BASE_CYC (`OPPT_INCR_MIN_NS / `OPPT_CLK_PERIOD_NS)
`define OPPT_DECADES       5
`define OPPT_SEL_W         3

`endif

//--- src/oppt_tick.v
// increment tick divider: one-cycle enable per selected increment period
// assumes the period select comes from fixed jumpers and restart is a pulse
`include "oppt_regs.vh"

module oppt_tick #(
   parameter BASE_CYC = `OPPT_INCR_BASE_CYC
) (
   input  wire                    core_clk,
   input  wire                    sys_rst,
   input  wire                    restart,
   input  wire [`OPPT_SEL_W-1:0]  period_sel,
   output reg                     tick_r
);

   // ----------------------------------------------------------------------
   // 1 us base prescaler
   // ----------------------------------------------------------------------
   reg  [15:0]                base_r;
   reg  [3:0]                 dec_r [0:`OPPT_DECADES-1];
   wire [`OPPT_DECADES:0]     stage;
   wire                       base_wrap;
   integer                    i;

   assign base_wrap = (base_r == BASE_CYC[15:0] - 16'h0001);
   assign stage[0]  = base_wrap;

   // decade chain keeps every counter small; 100 ms would need 10^7 cycles
   genvar g;
   generate
      for (g = 0; g < `OPPT_DECADES; g = g + 1) begin : dec
         assign stage[g+1] = stage[g] & (dec_r[g] == 4'h9);
      end
   endgenerate

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         base_r <= 16'h0000;
         for (i = 0; i < `OPPT_DECADES; i = i + 1)
            dec_r[i] <= 4'h0;
      end else if (restart) begin
         // restart aligns the first increment to the trigger
         base_r <= 16'h0000;
         for (i = 0; i < `OPPT_DECADES; i = i + 1)
            dec_r[i] <= 4'h0;
      end else begin
         base_r <= base_wrap ? 16'h0000 : base_r + 16'h0001;
         for (i = 0; i < `OPPT_DECADES; i = i + 1)
            if (stage[i])
               dec_r[i] <= (dec_r[i] == 4'h9) ? 4'h0 : dec_r[i] + 4'h1;
      end
   end

   // ----------------------------------------------------------------------
   // period select: 0 = 1 us ... 5 = 100 ms, higher codes clamp to 100 ms
   // ----------------------------------------------------------------------
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         tick_r <= 1'b0;
      else if (restart)
         tick_r <= 1'b0;
      else if (period_sel > `OPPT_DECADES)
         tick_r <= stage[`OPPT_DECADES];
      else
         tick_r <= stage[period_sel];  // [RL2]
   end

endmodule

//--- src/oppt_timer.v
// programmable one-shot pulse timer card with apb command port
// assumes an apb master on core_clk and jumper straps held static
//
// Summary of operation
// RL1 - pulse lasts the programmed count of increments, 1 to 4095
// RL2 - increment period set by jumpers only, 1 us up to 0.1 s
// RL3 - each command gives exactly one timed pulse; new command restarts it
// RL4 - with jumper, transfer-strobe control word or external pulse starts it
// RL5 - handshake: controller sends sync-only control word, then data word
// RL6 - handshake mode gives no completion signal to the controller
// RL7 - timing mode with completion jumper holds flag until pulse ends
// RL8 - timing mode: control word with xfer, sync, timing, then data word
// RL9 - timing-mode completion asserts the service request line
// RL10 - controller clears timing bit by control word after completion
// RL11 - interrupt mode without completion jumper interrupts when pulse ends
// RL12 - interrupt load: control word with select clear, then data word
// RL13 - selective arm: select, gated address word, arm plus timing word
// RL14 - auto-arm jumper arms on a single arm plus timing control word
// RL15 - ungated read in select mode returns request bit after completion
// RL16 - controller disarms with select clear and a zero data word
// RL17 - controller polls each card's request bit to find the source
// RL18 - leaving auto-arm jumper off everywhere is recommended
// RL19 - latch count, raise output on trigger, count down per tick to zero
// RL20 - request indication holds from completion until the zero disarm
`include "oppt_regs.vh"

module oppt_timer #(
   parameter COUNT_W  = `OPPT_COUNT_W,
   parameter BASE_CYC = `OPPT_INCR_BASE_CYC
) (
   input  wire                    core_clk,
   input  wire                    sys_rst,
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [31:0]             paddr,
   input  wire [31:0]             pwdata,
   output reg  [31:0]             prdata,
   output reg                     pready,
   output reg                     pslverr,
   input  wire [`OPPT_SEL_W-1:0]  period_sel,
   input  wire                    completion_flag_jumper,
   input  wire                    auto_arm_jumper,
   input  wire                    strobe_trig_jumper,
   input  wire                    ext_trig_jumper,
   input  wire                    ext_trig,
   output reg                     pulse_out_r,
   output reg                     flag_out_r,
   output reg                     srq_out_r,
   output reg                     irq_out_r
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   reg                     state_r;
   reg [`OPPT_CTRL_W-1:0]  ctrl_r;
   reg [COUNT_W-1:0]       count_r;
   reg [COUNT_W-1:0]       remain_r;
   reg                     selected_r;
   reg                     armed_r;
   reg                     req_r;
   reg                     ext_prev_r;
   reg                     timing_run_r;
   reg [31:0]              rd_word;

   wire                    acc;
   wire                    wr;
   wire [`OPPT_ADDR_W-1:0] ofs;
   wire                    mapped;
   wire                    tick;
   wire                    wr_ctrl;
   wire                    wr_data;
   wire                    wr_addrw;
   wire [COUNT_W-1:0]      wr_count;
   wire                    start;
   wire                    start_strobe;
   wire                    start_ext;
   wire                    start_data;
   wire                    done;
   wire                    disarm;
   wire                    arm_cmd;
   wire                    timing_start;
   wire                    irq_set;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function is_mapped;
      input [`OPPT_ADDR_W-1:0] a;
      begin
         is_mapped = (a == `OPPT_OFS_CTRL) || (a == `OPPT_OFS_DATA) ||
                     (a == `OPPT_OFS_ADDRW) || (a == `OPPT_OFS_READBACK) ||
                     (a == `OPPT_OFS_STATUS);
      end
   endfunction

   function [31:0] pad_count;
      input [COUNT_W-1:0] c;
      begin
         pad_count = {{(32-COUNT_W){1'b0}}, c};
      end
   endfunction

   // ----------------------------------------------------------------------
   // apb decode: a transfer completes on the edge that sees pready high
   // ----------------------------------------------------------------------
   // word map: ctrl 00 rw, data 04 rw, addrw 08 wo, readback 0c ro,
   // status 10 ro; writes to the read-only words are dropped quietly
   // status: b0 run, b1 selected, b2 armed, b3 flag, b4 srq, b5 req
   // any other address answers pslverr and reads zero
   assign acc    = psel & penable & pready;
   assign ofs    = paddr[`OPPT_ADDR_W-1:0];
   assign mapped = (paddr[31:`OPPT_ADDR_W] == 27'h0) & is_mapped(ofs);
   assign wr     = acc & pwrite & mapped;

   assign wr_ctrl  = wr & (ofs == `OPPT_OFS_CTRL);
   assign wr_data  = wr & (ofs == `OPPT_OFS_DATA);
   assign wr_addrw = wr & (ofs == `OPPT_OFS_ADDRW);
   assign wr_count = pwdata[COUNT_W-1:0];

   // read mux on the low offset bits only; high bits are screened below
   always @* begin
      case (ofs)
         `OPPT_OFS_CTRL:
            rd_word = {27'h0, ctrl_r};
         `OPPT_OFS_DATA:
            rd_word = pad_count(count_r);
         `OPPT_OFS_READBACK:
            // ungated select-mode readback: request in bit 15
            rd_word = pad_count(count_r) |  // [RL15]
                      {16'h0, req_r & ctrl_r[`OPPT_BIT_ISEL], 15'h0};
         `OPPT_OFS_STATUS:
            rd_word = {26'h0, req_r, srq_out_r, flag_out_r,
                       armed_r, selected_r, state_r};
         default:
            rd_word = 32'h0000_0000;
      endcase
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (psel & penable & ~pready) begin
         // one wait state gives registered read data and error
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= mapped ? rd_word : 32'h0000_0000;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------------
   // trigger sources
   // ----------------------------------------------------------------------
   // with neither trigger jumper, a data word with select clear starts it
   assign start_data   = wr_data & ~ctrl_r[`OPPT_BIT_ISEL] &
                         (wr_count != `OPPT_COUNT_RST) &
                         ~strobe_trig_jumper & ~ext_trig_jumper;  // [RL3]
   assign start_strobe = wr_ctrl & pwdata[`OPPT_BIT_XFER] &
                         strobe_trig_jumper &
                         (count_r != `OPPT_COUNT_RST);  // [RL4]
   // external trigger is sampled as a synchronous level; rising edge fires
   assign start_ext    = ext_trig_jumper & ext_trig & ~ext_prev_r &
                         (count_r != `OPPT_COUNT_RST);  // [RL4]
   assign start        = start_data | start_strobe | start_ext;

   assign done    = (state_r == ST_RUN) & tick &
                    (remain_r == {{(COUNT_W-1){1'b0}}, 1'b1}) & ~start;
   assign disarm  = wr_data & ~ctrl_r[`OPPT_BIT_ISEL] &
                    (wr_count == `OPPT_COUNT_RST);  // [RL16]
   assign arm_cmd = wr_ctrl & pwdata[`OPPT_BIT_ARM] &
                    pwdata[`OPPT_BIT_TIMING];

   oppt_tick #(
      .BASE_CYC   (BASE_CYC)
   ) u_tick (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .restart    (start),
      .period_sel (period_sel),
      .tick_r     (tick)
   );

   // ----------------------------------------------------------------------
   // command word registers
   // ----------------------------------------------------------------------
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         ctrl_r <= `OPPT_CTRL_RST;
      else if (wr_ctrl)
         ctrl_r <= pwdata[`OPPT_CTRL_W-1:0];
   end

   // data words only load when the card is not in select mode
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         count_r <= `OPPT_COUNT_RST;
      else if (wr_data & ~ctrl_r[`OPPT_BIT_ISEL])
         count_r <= wr_count;  // [RL1] [RL19]
   end

   // gate only taken in select mode; a select-clear word drops it
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         selected_r <= 1'b0;
      else if (wr_addrw & ctrl_r[`OPPT_BIT_ISEL])
         selected_r <= pwdata[`OPPT_BIT_GATE];  // [RL13]
      else if (wr_ctrl & ~pwdata[`OPPT_BIT_ISEL])
         selected_r <= 1'b0;
   end

   // previous trigger level for the rising-edge detect
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         ext_prev_r <= 1'b0;
      else
         ext_prev_r <= ext_trig;
   end

   // ----------------------------------------------------------------------
   // pulse sequencer
   // ----------------------------------------------------------------------
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r     <= ST_IDLE;
         remain_r    <= `OPPT_COUNT_RST;
         pulse_out_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r     <= ST_RUN;
                  remain_r    <= start_data ? wr_count : count_r;
                  pulse_out_r <= 1'b1;  // [RL19]
               end
            end
            ST_RUN: begin
               if (start) begin
                  // a fresh command restarts the full length
                  remain_r <= start_data ? wr_count : count_r;  // [RL3]
               end else if (done) begin
                  state_r     <= ST_IDLE;
                  remain_r    <= `OPPT_COUNT_RST;
                  pulse_out_r <= 1'b0;  // [RL19]
               end else if (tick) begin
                  remain_r <= remain_r - {{(COUNT_W-1){1'b0}}, 1'b1};  // [RL1]
               end
            end
            default: begin
               state_r     <= ST_IDLE;
               pulse_out_r <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // completion reporting
   // ----------------------------------------------------------------------
   // handshake mode (timing bit clear) never raises flag or srq  [RL6]
   // timing bit may sit in ctrl_r or come with the triggering word
   assign timing_start = start & completion_flag_jumper &
                         (ctrl_r[`OPPT_BIT_TIMING] |
                          (wr_ctrl & pwdata[`OPPT_BIT_TIMING]));

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         timing_run_r <= 1'b0;
      else if (timing_start)
         timing_run_r <= 1'b1;
      else if (done)
         timing_run_r <= 1'b0;
   end

   // flag held for the whole pulse; its falling edge marks the end
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         flag_out_r <= 1'b0;
      else if (timing_start)
         flag_out_r <= 1'b1;  // [RL7]
      else if (done)
         flag_out_r <= 1'b0;  // [RL7]
   end

   // set wins over the clearing control word
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         srq_out_r <= 1'b0;
      else if (done & timing_run_r)
         srq_out_r <= 1'b1;  // [RL9]
      else if (wr_ctrl & ~pwdata[`OPPT_BIT_TIMING])
         srq_out_r <= 1'b0;  // [RL10]
   end

   // ----------------------------------------------------------------------
   // interrupt mode: arm, request, disarm
   // ----------------------------------------------------------------------
   assign irq_set = done & armed_r & ~completion_flag_jumper;

   // arming is ignored while the completion jumper is fitted
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         armed_r <= 1'b0;
      else if (arm_cmd & ~completion_flag_jumper &
               (selected_r | auto_arm_jumper))
         armed_r <= 1'b1;  // [RL13] [RL14]
      else if (disarm)
         armed_r <= 1'b0;  // [RL16]
   end

   // completion outranks a disarm landing in the same cycle
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         req_r <= 1'b0;
      else if (irq_set)
         req_r <= 1'b1;  // [RL11] [RL20]
      else if (disarm)
         req_r <= 1'b0;  // [RL20]
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         irq_out_r <= 1'b0;
      else if (irq_set)
         irq_out_r <= 1'b1;  // [RL11]
      else if (disarm)
         irq_out_r <= 1'b0;
   end

endmodule

//--- dv/oppt_timer_checker.sv
// port assertions for the one-shot pulse timer card
// assumes BASE_CYC of 4 or more, so a pulse spans three cycles at least
`include "oppt_regs.vh"

module oppt_timer_checker #(
   parameter COUNT_W  = `OPPT_COUNT_W,
   parameter BASE_CYC = `OPPT_INCR_BASE_CYC
) (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        completion_flag_jumper,
   input wire logic        ext_trig_jumper,
   input wire logic        pulse_out_r,
   input wire logic        flag_out_r,
   input wire logic        srq_out_r,
   input wire logic        irq_out_r
);
   timeunit 1ns;
   timeprecision 1ps;
   logic zero_wr;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // a zero count written to the data register also disarms
   assign zero_wr = psel && penable && pready && pwrite &&
      paddr == 32'(`OPPT_OFS_DATA) && pwdata[11:0] == 12'h000;

   a_ready_once: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   a_ready_late: assert property
      (psel && !penable ##1 psel && penable |=> pready)
      else $error("pready missing in second access cycle");
   a_err_unmapped: assert property
      (pready && paddr[31:5] != 27'h0 |-> pslverr)
      else $error("unmapped access not refused");
   a_zero_count: assert property (
      zero_wr && !pulse_out_r && !ext_trig_jumper |=> !pulse_out_r)
      else $error("zero count started a pulse");
   a_pulse_min: assert property (
      $rose(pulse_out_r) |-> pulse_out_r[*3])
      else $error("pulse shorter than one increment");
   a_flag_srq: assert property (
      $fell(flag_out_r) |-> ##[0:1] srq_out_r)
      else $error("flag fell without service request");
   a_irq_end: assert property (
      $rose(irq_out_r) |-> $fell(pulse_out_r) && !completion_flag_jumper)
      else $error("irq rose away from pulse end");
   a_irq_hold: assert property (
      irq_out_r && !zero_wr |=> irq_out_r)
      else $error("irq dropped without disarm");

   cover property ($fell(pulse_out_r));
   cover property ($rose(srq_out_r));
   cover property ($rose(irq_out_r));
endmodule

bind oppt_timer oppt_timer_checker #(
   .COUNT_W(COUNT_W),
   .BASE_CYC(BASE_CYC)
) u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr),
   .completion_flag_jumper(completion_flag_jumper),
   .ext_trig_jumper(ext_trig_jumper), .pulse_out_r(pulse_out_r),
   .flag_out_r(flag_out_r), .srq_out_r(srq_out_r), .irq_out_r(irq_out_r)
);

//--- dv/oppt_host.sv
// host controller model: apb master and the card command sequences
// assumes it is the only master and is called just after a rising edge
`include "oppt_regs.vh"

module oppt_host (
   input  wire logic        core_clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel    = 1'b0,
   output logic             penable = 1'b0,
   output logic             pwrite  = 1'b0,
   output logic [31:0]      paddr   = 32'h0,
   output logic [31:0]      pwdata  = 32'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_CTRL = 32'(`OPPT_OFS_CTRL);
   localparam logic [31:0] A_DATA = 32'(`OPPT_OFS_DATA);
   logic [31:0] q;
   logic        e;

   task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // a released bus shows junk, never the last address or data
      paddr  <= ~a;
      pwdata <= ~d;
      @(posedge core_clk);
   endtask

   task automatic handshake(input logic [11:0] n);
      xfer(1'b1, A_CTRL, 32'h2);
      xfer(1'b1, A_DATA, {20'h0, n});
   endtask
   task automatic timing_go(input logic [11:0] n);
      xfer(1'b1, A_CTRL, 32'h7);
      xfer(1'b1, A_DATA, {20'h0, n});
   endtask
   task automatic int_load(input logic [11:0] n);
      xfer(1'b1, A_CTRL, 32'h0);
      xfer(1'b1, A_DATA, {20'h0, n});
   endtask
   // select and gate first unless the card arms itself on one word
   task automatic arm(input logic sel);
      if (sel) begin
         xfer(1'b1, A_CTRL, 32'h8);
         xfer(1'b1, 32'(`OPPT_OFS_ADDRW), 32'h1);
      end
      xfer(1'b1, A_CTRL, 32'h14);
   endtask
   task automatic poll_req;
      xfer(1'b1, A_CTRL, 32'h8);
      xfer(1'b0, 32'(`OPPT_OFS_READBACK), 32'h0);
   endtask
   task automatic disarm;
      xfer(1'b1, A_CTRL, 32'h0);
      xfer(1'b1, A_DATA, 32'h0);
   endtask
endmodule

//--- dv/tb.sv
// self-checking bench for the one-shot pulse timer card
// assumes the host model drives apb; BASE_CYC cut to 4 for short runs
`include "oppt_regs.vh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BASE = 4;
   logic                   core_clk = 1'b0;
   logic                   sys_rst  = 1'b1;
   logic                   psel, penable, pwrite, pready, pslverr;
   logic [31:0]            paddr, pwdata, prdata;
   logic [`OPPT_SEL_W-1:0] period_sel = '0;
   logic                   comp_j = 1'b0, strobe_j = 1'b0, ext_j = 1'b0;
   logic                   auto_j = 1'b0;
   logic                   ext_trig = 1'b0;
   logic                   pulse_out_r, flag_out_r, srq_out_r, irq_out_r;
   int err_total = 0, checked = 0, cyc = 0, run_w = 0, last_w = 0;
   int n_pulse = 0, n0, seed = 89;
   int hs_n[6] = '{1, 4095, 3, 2, 1, 9};
   int hs_s[6] = '{0, 0, 1, 2, 3, 0};

   always #5 core_clk = ~core_clk;

   oppt_timer #(.BASE_CYC(BASE)) u_oppt_timer (
      .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .period_sel(period_sel),
      .completion_flag_jumper(comp_j), .auto_arm_jumper(auto_j),
      .strobe_trig_jumper(strobe_j), .ext_trig_jumper(ext_j),
      .ext_trig(ext_trig), .pulse_out_r(pulse_out_r),
      .flag_out_r(flag_out_r), .srq_out_r(srq_out_r),
      .irq_out_r(irq_out_r)
   );
   oppt_host u_oppt_host (
      .core_clk(core_clk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // prescaler restart at the trigger leaves a cycle or two of slack
   function automatic logic near(input int w, input int x);
      return w >= x - 2 && w <= x + 2;
   endfunction
   task automatic wait_pulse;
      while (n_pulse == n0) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
   endtask
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------
   // pulse width monitor, timeout
   // ----------------------------
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (pulse_out_r === 1'b1) begin
         run_w <= run_w + 1;
      end else if (run_w != 0) begin
         last_w  <= run_w;
         run_w   <= 0;
         n_pulse <= n_pulse + 1;
      end
      if (cyc == 40000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      chk(32'({pulse_out_r, flag_out_r, srq_out_r, irq_out_r}), 32'h0);
      u_oppt_host.xfer(1'b0, 32'h0000_0014, 32'h0);
      chk(u_oppt_host.q, 32'h0);
      chk(32'(u_oppt_host.e), 32'h1);
      hs_n[5] = 1 + ($random(seed) & 63);
      for (int i = 0; i < 6; i++) begin
         period_sel <= hs_s[i][2:0];
         n0 = n_pulse;
         u_oppt_host.handshake(12'(hs_n[i]));
         wait_pulse();
         chk(32'(near(last_w, hs_n[i] * BASE * 10 ** hs_s[i])),
            32'h1);
         chk(32'({n_pulse - n0 == 1, flag_out_r, srq_out_r, irq_out_r}),
            32'h8);
      end
      n0 = n_pulse;
      // high address bits alias the data word's offset: must read zero
      u_oppt_host.xfer(1'b0, 32'h0000_0104, 32'h0);
      chk(u_oppt_host.q, 32'h0);
      chk(32'(u_oppt_host.e), 32'h1);
      u_oppt_host.handshake(12'h000);
      repeat (20) @(posedge core_clk);
      chk(32'(n_pulse - n0), 32'h0);
      u_oppt_host.handshake(12'd20);
      u_oppt_host.handshake(12'd20);
      wait_pulse();
      chk(32'(last_w > 20 * BASE && n_pulse - n0 == 1), 32'h1);
      comp_j <= 1'b1;
      n0 = n_pulse;
      u_oppt_host.timing_go(12'd30);
      repeat (3) @(posedge core_clk);
      chk(32'({pulse_out_r, flag_out_r}), 32'h3);
      wait_pulse();
      chk(32'({flag_out_r, srq_out_r}), 32'h1);
      u_oppt_host.xfer(1'b1, 32'h0, 32'h0);
      @(posedge core_clk);
      chk(32'(srq_out_r), 32'h0);
      for (int j = 0; j < 2; j++) begin
         comp_j   <= 1'b0;
         strobe_j <= (j == 0);
         ext_j    <= (j == 1);
         n0 = n_pulse;
         u_oppt_host.xfer(1'b1, 32'h4, 32'd10);
         repeat (8) @(posedge core_clk);
         chk(32'(pulse_out_r), 32'h0);
         if (j == 0) begin
            u_oppt_host.xfer(1'b1, 32'h0, 32'h1);
         end else begin
            ext_trig <= 1'b1;
            repeat (2) @(posedge core_clk);
            ext_trig <= 1'b0;
         end
         wait_pulse();
         chk(32'(near(last_w, 10 * BASE)), 32'h1);
      end
      strobe_j <= 1'b0;
      ext_j    <= 1'b0;
      for (int j = 0; j < 3; j++) begin
         auto_j <= (j == 1);
         n0 = n_pulse;
         u_oppt_host.int_load(12'(8 + ($random(seed) & 31)));
         if (j < 2) begin
            u_oppt_host.arm(j == 0);
         end
         wait_pulse();
         chk(32'(irq_out_r), 32'(j < 2));
         u_oppt_host.poll_req();
         chk(32'(u_oppt_host.q >= 32'h8000), 32'(j < 2));
         repeat (20) @(posedge core_clk);
         chk(32'(irq_out_r), 32'(j < 2));
         u_oppt_host.disarm();
         chk(32'(irq_out_r), 32'h0);
      end
      complete_run();
   end
endmodule
